// ---- include/rfc_pkg.sv ----
// Package for the refresh control block: register map, fields, timing
package rfc_pkg;
  localparam int unsigned RFC_ADDR_W = 8;
  localparam int unsigned RFC_DATA_W = 32;
  localparam int unsigned RFC_CNT_W = 8;
  localparam int unsigned RFC_PRE_W = 12;
  // Register byte addresses
  localparam logic [7:0] RFC_OFF_CTRL = 8'h00;
  localparam logic [7:0] RFC_OFF_CSR = 8'h04;
  localparam logic [7:0] RFC_OFF_CNT = 8'h08;
  localparam logic [7:0] RFC_OFF_COR = 8'h0C;
  // Control register fields
  localparam int unsigned RFC_CTRL_EN_BIT = 2;
  localparam int unsigned RFC_CTRL_MODE_BIT = 1;
  localparam int unsigned RFC_CTRL_RSV_BIT = 0;
  // Timer control/status fields
  localparam int unsigned RFC_CSR_FLAG_BIT = 7;
  localparam int unsigned RFC_CSR_CKS_LO = 3;
  localparam int unsigned RFC_CSR_CKS_W = 3;
  // Reset values
  localparam logic [2:0] RFC_CTRL_RST = 3'h0;
  localparam logic [2:0] RFC_CKS_RST = 3'h0;
  localparam logic [7:0] RFC_CNT_RST = 8'h00;
  localparam logic [7:0] RFC_COR_RST = 8'hFF;
  // Length of one refresh cycle on the memory side, in clocks
  localparam logic [3:0] RFC_REFRESH_CYCLES = 4'h4;
  localparam logic [3:0] RFC_CYC_ONE = 4'h1;

  typedef enum logic [4:0] {
    RFC_IDLE = 5'b00001,
    RFC_WAIT_BUS = 5'b00010,
    RFC_REFRESH = 5'b00100,
    RFC_SELF_WAIT = 5'b01000,
    RFC_SELF = 5'b10000
  } rfc_state_t;

  // Commands toward the memory sequencer
  typedef struct packed {
    logic refresh_go;
    logic sdram_auto;
    logic self_enter;
    logic self_exit;
    logic self_active;
  } rfc_mem_cmd_t;
endpackage : rfc_pkg

// ---- rtl/rfc_prescaler.sv ----
// Free-running clock prescaler with selectable tick rate
`timescale 1ns/100ps
`default_nettype none
module rfc_prescaler
  import rfc_pkg::*;
#(
  parameter int unsigned PRE_W = RFC_PRE_W
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [2:0] clk_select,
  output logic tick
);
  logic [PRE_W-1:0] div_r;

  // Tick when the selected low bits of the divider all read zero; select 0 never ticks
  function automatic logic sel_tick(input logic [2:0] sel, input logic [PRE_W-1:0] d);
    logic t;
    t = 1'b0;
    unique case (sel)
      3'h0: t = 1'b0;
      3'h1: t = (d[1:0] == 2'h0);
      3'h2: t = (d[3:0] == 4'h0);
      3'h3: t = (d[5:0] == 6'h00);
      3'h4: t = (d[7:0] == 8'h00);
      3'h5: t = (d[9:0] == 10'h000);
      3'h6: t = (d[10:0] == 11'h000);
      3'h7: t = (d[11:0] == 12'h000);
    endcase
    return t;
  endfunction : sel_tick

  // Divider counter
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      div_r <= '0;
    end else begin
      div_r <= div_r + 1'b1;
    end
  end

  assign tick = sel_tick(clk_select, div_r);
endmodule : rfc_prescaler
`default_nettype wire

// ---- rtl/rfc_timer.sv ----
// Refresh interval counter with compare against the time constant
`timescale 1ns/100ps
`default_nettype none
module rfc_timer
  import rfc_pkg::*;
#(
  parameter int unsigned CNT_W = RFC_CNT_W
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic tick,
  input wire logic cnt_wr,
  input wire logic [CNT_W-1:0] cnt_wdata,
  input wire logic [CNT_W-1:0] time_constant,
  output logic [CNT_W-1:0] count,
  output logic match
);
  logic [CNT_W-1:0] cnt_r;

  // Count on each tick, wrap to zero on compare match; software write wins
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_r <= '0;
    end else if (cnt_wr) begin
      cnt_r <= cnt_wdata;
    end else if (tick) begin
      if (cnt_r == time_constant) begin
        cnt_r <= '0;
      end else begin
        cnt_r <= cnt_r + 1'b1;
      end
    end
  end

  assign count = cnt_r;
  assign match = tick && !cnt_wr && (cnt_r == time_constant);
endmodule : rfc_timer
`default_nettype wire

// ---- rtl/rfc_refresh_ctrl.sv ----
// Refresh control: enable/mode register, refresh timer and refresh sequencing
//
// Functional notes
// - Refresh cycles are issued only while refresh_enable is set.
// - The refresh timer also works as an interval timer with a sticky flag.
// - Enable set, mode clear: periodic refresh at the programmed timer period.
// - A periodic request during a bus cycle ends that cycle, then refreshes.
// - Enable and mode set: wait for bus cycle end, then enter self-refresh.
// - In self-refresh all refresh requests are ignored, no refresh issued.
// - Reserved control bit 0 reads zero; software writes zero.
//
// The placing of the registers and strobed register access were decided locally.
`timescale 1ns/100ps
`default_nettype none
module rfc_refresh_ctrl
  import rfc_pkg::*;
#(
  parameter int unsigned CNT_W = RFC_CNT_W,
  parameter logic [3:0] REFRESH_CYCLES = RFC_REFRESH_CYCLES
) (
  input wire logic clk,
  input wire logic rst,
  // Register port
  input wire logic [RFC_ADDR_W-1:0] reg_addr,
  input wire logic [RFC_DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [RFC_DATA_W-1:0] reg_rdata,
  // External bus controller
  input wire logic bus_busy,
  output logic bus_end_req,
  // Memory type: high for synchronous DRAM, low for DRAM
  input wire logic sdram_sel,
  // Memory command outputs
  output rfc_mem_cmd_t mem_cmd,
  output logic interval_flag
);
  logic refresh_enable_r;
  logic refresh_mode_select_r;
  logic [2:0] cks_r;
  logic flag_r;
  logic [CNT_W-1:0] cor_r;
  logic [CNT_W-1:0] count;
  logic tick;
  logic match;
  logic pend_r;
  logic [3:0] cyc_r;
  rfc_state_t state_r;
  rfc_state_t state_nxt;
  logic [RFC_DATA_W-1:0] rdata_r;
  logic [RFC_DATA_W-1:0] rd_mux;
  logic go_r;
  logic enter_r;
  logic exit_r;
  logic wr_ctrl;
  logic wr_csr;
  logic wr_cnt;
  logic wr_cor;
  logic periodic_on;
  logic self_on;

  // Register write decodes
  assign wr_ctrl = reg_wr && (reg_addr == RFC_OFF_CTRL);
  assign wr_csr = reg_wr && (reg_addr == RFC_OFF_CSR);
  assign wr_cnt = reg_wr && (reg_addr == RFC_OFF_CNT);
  assign wr_cor = reg_wr && (reg_addr == RFC_OFF_COR);

  // Mode decode from the control bits
  assign periodic_on = refresh_enable_r && !refresh_mode_select_r;
  assign self_on = refresh_enable_r && refresh_mode_select_r;

  // Timer clock source
  rfc_prescaler #(
    .PRE_W(RFC_PRE_W)
  ) u_pre (
    .clk(clk),
    .rst(rst),
    .clk_select(cks_r),
    .tick(tick)
  );

  // Refresh interval counter, free to run as an interval timer
  rfc_timer #(
    .CNT_W(CNT_W)
  ) u_tmr (
    .clk(clk),
    .rst(rst),
    .tick(tick),
    .cnt_wr(wr_cnt),
    .cnt_wdata(reg_wdata[CNT_W-1:0]),
    .time_constant(cor_r),
    .count(count),
    .match(match)
  );

  // Control register: enable and mode; reserved bit is not stored
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      refresh_enable_r <= RFC_CTRL_RST[RFC_CTRL_EN_BIT];
      refresh_mode_select_r <= RFC_CTRL_RST[RFC_CTRL_MODE_BIT];
    end else if (wr_ctrl) begin
      refresh_enable_r <= reg_wdata[RFC_CTRL_EN_BIT];
      refresh_mode_select_r <= reg_wdata[RFC_CTRL_MODE_BIT];
    end
  end

  // Timer clock select and time constant
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cks_r <= RFC_CKS_RST;
      cor_r <= RFC_COR_RST[CNT_W-1:0];
    end else begin
      if (wr_csr) begin
        cks_r <= reg_wdata[RFC_CSR_CKS_LO +: RFC_CSR_CKS_W];
      end
      if (wr_cor) begin
        cor_r <= reg_wdata[CNT_W-1:0];
      end
    end
  end

  // Sticky compare flag; written 0 clears it, a match in the same cycle wins
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      flag_r <= 1'b0;
    end else if (match) begin
      flag_r <= 1'b1;
    end else if (wr_csr && !reg_wdata[RFC_CSR_FLAG_BIT]) begin
      flag_r <= 1'b0;
    end
  end

  // Pending periodic request; dropped when refresh is off or in self-refresh
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pend_r <= 1'b0;
    end else if (match && periodic_on && (state_r != RFC_SELF)) begin
      pend_r <= 1'b1;
    end else if (!periodic_on || state_r == RFC_SELF) begin
      pend_r <= 1'b0;
    end else if (state_r == RFC_REFRESH && cyc_r == RFC_CYC_ONE) begin
      pend_r <= 1'b0;
    end
  end

  // Sequencer next state
  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      RFC_IDLE: begin
        if (self_on) begin
          state_nxt = RFC_SELF_WAIT;
        end else if (pend_r && periodic_on) begin
          state_nxt = RFC_WAIT_BUS;
        end
      end
      RFC_WAIT_BUS: begin
        if (!periodic_on) begin
          state_nxt = RFC_IDLE;
        end else if (!bus_busy) begin
          state_nxt = RFC_REFRESH;
        end
      end
      RFC_REFRESH: begin
        if (cyc_r == RFC_CYC_ONE) begin
          state_nxt = RFC_IDLE;
        end
      end
      RFC_SELF_WAIT: begin
        if (!self_on) begin
          state_nxt = RFC_IDLE;
        end else if (!bus_busy) begin
          state_nxt = RFC_SELF;
        end
      end
      RFC_SELF: begin
        if (!self_on) begin
          state_nxt = RFC_IDLE;
        end
      end
      default: state_nxt = RFC_IDLE;
    endcase
  end

  // State register
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_r <= RFC_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  // Refresh cycle length counter
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cyc_r <= 4'h0;
    end else if (state_r == RFC_WAIT_BUS && state_nxt == RFC_REFRESH) begin
      cyc_r <= REFRESH_CYCLES;
    end else if (state_r == RFC_REFRESH && cyc_r != 4'h0) begin
      cyc_r <= cyc_r - 1'b1;
    end
  end

  // One-cycle command pulses toward the memory sequencer
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      go_r <= 1'b0;
      enter_r <= 1'b0;
      exit_r <= 1'b0;
    end else begin
      go_r <= (state_r == RFC_WAIT_BUS) && (state_nxt == RFC_REFRESH);
      enter_r <= (state_r == RFC_SELF_WAIT) && (state_nxt == RFC_SELF);
      exit_r <= (state_r == RFC_SELF) && (state_nxt != RFC_SELF);
    end
  end

  // Ask the bus controller to close its cycle while a periodic refresh waits
  assign bus_end_req = (state_r == RFC_WAIT_BUS) && bus_busy;

  // Command bundle; no refresh pulse can come from the self-refresh state
  assign mem_cmd.refresh_go = go_r;
  assign mem_cmd.sdram_auto = sdram_sel;
  assign mem_cmd.self_enter = enter_r;
  assign mem_cmd.self_exit = exit_r;
  assign mem_cmd.self_active = (state_r == RFC_SELF);
  assign interval_flag = flag_r;

  // Read multiplexer; unmapped addresses read zero
  always_comb begin
    rd_mux = '0;
    unique case (reg_addr)
      RFC_OFF_CTRL: begin
        rd_mux[RFC_CTRL_EN_BIT] = refresh_enable_r;
        rd_mux[RFC_CTRL_MODE_BIT] = refresh_mode_select_r;
        rd_mux[RFC_CTRL_RSV_BIT] = 1'b0;
      end
      RFC_OFF_CSR: begin
        rd_mux[RFC_CSR_FLAG_BIT] = flag_r;
        rd_mux[RFC_CSR_CKS_LO +: RFC_CSR_CKS_W] = cks_r;
      end
      RFC_OFF_CNT: rd_mux[CNT_W-1:0] = count;
      RFC_OFF_COR: rd_mux[CNT_W-1:0] = cor_r;
      default: rd_mux = '0;
    endcase
  end

  // Read data stand in the cycle after the strobe only
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rdata_r <= '0;
    end else if (reg_rd) begin
      rdata_r <= rd_mux;
    end else begin
      rdata_r <= '0;
    end
  end

  assign reg_rdata = rdata_r;
endmodule : rfc_refresh_ctrl
`default_nettype wire

// ---- testbench/rfc_refresh_ctrl_properties.sv ----
// Concurrent checks on the refresh control ports
`timescale 1ns/100ps
`default_nettype none
module rfc_refresh_ctrl_properties
  import rfc_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic [RFC_ADDR_W-1:0] reg_addr,
  input wire logic reg_rd,
  input wire logic [RFC_DATA_W-1:0] reg_rdata,
  input wire logic bus_busy,
  input wire logic bus_end_req,
  input wire logic sdram_sel,
  input wire rfc_mem_cmd_t mem_cmd
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // Refresh pulse is single and cannot recur inside one refresh cycle
  a_go_one_pulse: assert property (mem_cmd.refresh_go |=> !mem_cmd.refresh_go [*3])
    else $error("refresh pulse repeated too soon");
  a_auto_type: assert property (mem_cmd.sdram_auto == sdram_sel)
    else $error("refresh type does not follow memory select");
  a_end_needs_busy: assert property (bus_end_req |-> bus_busy)
    else $error("bus end request without a bus cycle");
  a_go_bus_free: assert property (mem_cmd.refresh_go |-> !$past(bus_busy))
    else $error("refresh started over a bus cycle");
  a_enter_bus_free: assert property (mem_cmd.self_enter |-> !$past(bus_busy))
    else $error("self refresh entered over a bus cycle");
  a_enter_active: assert property (mem_cmd.self_enter |-> mem_cmd.self_active)
    else $error("self refresh entry without active state");
  a_self_no_go: assert property (mem_cmd.self_active |-> !mem_cmd.refresh_go)
    else $error("refresh issued during self refresh");
  a_exit_falls: assert property (mem_cmd.self_exit |-> !mem_cmd.self_active && $past(mem_cmd.self_active))
    else $error("self refresh exit misplaced");
  a_rdata_quiet: assert property (!$past(reg_rd) |-> reg_rdata == '0)
    else $error("read data outside the read cycle");
  a_rsv_zero: assert property ($past(reg_rd) && $past(reg_addr) == RFC_OFF_CTRL |-> !reg_rdata[RFC_CTRL_RSV_BIT])
    else $error("reserved control bit read as one");
endmodule : rfc_refresh_ctrl_properties
bind rfc_refresh_ctrl rfc_refresh_ctrl_properties u_props (.clk(clk), .rst(rst),
  .reg_addr(reg_addr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .bus_busy(bus_busy),
  .bus_end_req(bus_end_req), .sdram_sel(sdram_sel), .mem_cmd(mem_cmd));
`default_nettype wire

// ---- testbench/rfc_mem_model.sv ----
// Memory-side model: counts refreshes and tracks self refresh
`timescale 1ns/100ps
`default_nettype none
module rfc_mem_model
  import rfc_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire rfc_mem_cmd_t cmd,
  output var int n_ref,
  output var int n_bad,
  output var logic in_self
);
  // A refresh or a second entry while self refreshing is counted as a fault
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      n_ref <= 0;
      n_bad <= 0;
      in_self <= 1'b0;
    end else begin
      if (cmd.refresh_go) n_ref <= n_ref + 1;
      if ((cmd.refresh_go || cmd.self_enter) && in_self) n_bad <= n_bad + 1;
      if (cmd.self_enter) in_self <= 1'b1;
      else if (cmd.self_exit) in_self <= 1'b0;
    end
  end
endmodule : rfc_mem_model
`default_nettype wire

// ---- testbench/rfc_refresh_ctrl_tb.sv ----
// Self-checking bench for the refresh control block
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, e) begin checks++; if ((a) !== (e)) begin n_mismatch++; $display("mismatch t=%0t got=%0h exp=%0h", $time, (a), (e)); end end
module rfc_refresh_ctrl_tb
  import rfc_pkg::*;
;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic bus_busy = 1'b0;
  logic sdram_sel = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic [31:0] reg_rdata;
  logic bus_end_req;
  logic interval_flag;
  logic in_self;
  rfc_mem_cmd_t mem_cmd;
  int n_mismatch = 0;
  int checks = 0;
  int n_ref, n_bad, c, r0, cst;

  always #5 clk = ~clk;

  rfc_refresh_ctrl DUT (.clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .bus_busy(bus_busy),
    .bus_end_req(bus_end_req), .sdram_sel(sdram_sel), .mem_cmd(mem_cmd),
    .interval_flag(interval_flag));
  rfc_mem_model u_mem (.clk(clk), .rst(rst), .cmd(mem_cmd), .n_ref(n_ref), .n_bad(n_bad),
    .in_self(in_self));

  // Register bus cycles and waits
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 `CHK(reg_rdata, e)
  endtask : rd
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask : cyc
  // Refresh period in clocks at divide-by-4 ticks
  function automatic int period(input int k);
    return (k + 1) * 4;
  endfunction : period
  function automatic bit near(input int n, input int w, input int p);
    return (n >= w / p - 1) && (n <= w / p + 1);
  endfunction : near
  task automatic wrap_up;
    $display("checks=%0d n_mismatch=%0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : wrap_up

  // Main sequence
  initial begin
    c = $urandom(48024);
    cyc(5);
    rst <= 1'b0;
    rd(RFC_OFF_CTRL, 32'h0);
    rd(RFC_OFF_CSR, 32'h0);
    rd(RFC_OFF_CNT, 32'h0);
    rd(RFC_OFF_COR, 32'hFF);
    rd(8'h10, 32'h0);
    cst = 3 + $urandom_range(7);
    wr(RFC_OFF_COR, cst);
    wr(RFC_OFF_CSR, 32'h08);
    cyc(period(cst) + 8);
    `CHK(interval_flag, 1'b1)
    rd(RFC_OFF_CSR, 32'h88);
    `CHK(n_ref, 0)
    wr(RFC_OFF_CTRL, 32'h0);
    cyc(3 * period(cst));
    `CHK(n_ref, 0)
    `CHK(mem_cmd.self_active, 1'b0)
    // Periodic refresh under random bus traffic
    wr(RFC_OFF_CTRL, 32'h4);
    r0 = n_ref;
    repeat (400) begin
      @(posedge clk);
      bus_busy <= ($urandom_range(3) == 0);
      sdram_sel <= $urandom_range(1);
    end
    `CHK(near(n_ref - r0, 400, period(cst)), 1'b1)
    // Long bus cycle: end requested, refresh only after release
    @(posedge clk);
    bus_busy <= 1'b1;
    c = 0;
    while (!bus_end_req && c < 200) begin
      @(posedge clk);
      c++;
    end
    r0 = n_ref;
    `CHK(bus_end_req, 1'b1)
    cyc(5);
    `CHK(n_ref, r0)
    bus_busy <= 1'b0;
    cyc(4);
    `CHK(n_ref, r0 + 1)
    // Self refresh waits for the bus; reserved bit reads back zero
    bus_busy <= 1'b1;
    wr(RFC_OFF_CTRL, 32'h6);
    rd(RFC_OFF_CTRL, 32'h6);
    cyc(10);
    `CHK(in_self, 1'b0)
    bus_busy <= 1'b0;
    cyc(4);
    `CHK(in_self, 1'b1)
    r0 = n_ref;
    cyc(4 * period(cst));
    `CHK(n_ref, r0)
    `CHK(mem_cmd.self_active, in_self)
    wr(RFC_OFF_CTRL, 32'h0);
    cyc(3);
    `CHK(in_self, 1'b0)
    `CHK(n_bad, 0)
    wrap_up;
  end

  // Watchdog against a hung sequence
  initial begin
    #100000;
    n_mismatch++;
    wrap_up;
  end
endmodule : rfc_refresh_ctrl_tb
`default_nettype wire
